// [inc/hv_wake_pkg.sv]
// constants, register map and pin carriers of the wake pin / hv interrupt block
package hv_wake_pkg;
    // clock and timing
    localparam int CLK_HZ = 20_000_000;
    localparam int HV_LAT_NS = 10_000;
    localparam int HV_LAT_CYC = (HV_LAT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int WAKE_TMO_MS = 1300;
    localparam int WAKE_TMO_CYC = WAKE_TMO_MS * (CLK_HZ / 1000);
    localparam int WAKE_SC_US = 400;
    localparam int WAKE_SC_CYC = WAKE_SC_US * (CLK_HZ / 1_000_000);
    localparam int LIN_SC_US = 20;
    localparam int LIN_SC_CYC = LIN_SC_US * (CLK_HZ / 1_000_000);

    // register byte offsets
    localparam logic [7:0] OFS_CFG_FIRST = 8'h00;
    localparam logic [7:0] OFS_CFG_SECOND = 8'h04;
    localparam logic [7:0] OFS_MONITOR = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_COMMAND = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

    // reset values
    localparam logic [7:0] CFG_FIRST_RST = 8'h00;
    localparam logic [7:0] CFG_SECOND_RST = 8'h00;

    // field positions
    localparam int CFG0_LVF_EN = 2;
    localparam int CFG0_DRIVE = 4;
    localparam int CFG0_KEEP_ON_HOT = 7;
    localparam int CFG1_NO_TMO = 1;
    localparam int CFG1_REARM = 3;
    localparam int CFG1_IO_MODE = 4;
    localparam int CFG1_OC_DIAG = 5;
    localparam int MON_WAKE_SC = 0;
    localparam int MON_LIN_SC = 2;
    localparam int MON_LVF = 3;
    localparam int MON_HOT = 6;
    localparam int MON_PIN = 7;
    localparam int CMD_BUSY = 0;
    localparam int CPU_IRQ_ENABLE_HV = 16;

    // interrupt sources
    localparam int N_SRC = 5;
    localparam int SRC_WAKE_SC = 0;
    localparam int SRC_LIN_SC = 1;
    localparam int SRC_HOT = 2;
    localparam int SRC_EDGE = 3;
    localparam int SRC_LVF = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic wake_pin_in;
        logic wake_overcurrent;
        logic lin_overcurrent;
        logic lin_drive_low;
        logic thermal_event;
        logic supply_low;
    } hv_pins_in_t;

    typedef struct packed {
        logic wake_pin_out;
        logic wake_pin_oe_n;
        logic pulldown_en;
        logic oc_res_en;
    } hv_pins_out_t;
endpackage

// [logic/hv_wake_pin_and_irq_status.sv]
// wake pin driver, fault qualification, low supply flag and hv interrupt snapshot
//
// Behaviour
// - reset: output mode, pull-down, high-side drive
// - first config bit 4 asserts wake driver
// - config changes reach pin after 10us
// - timeout enabled, drops driver after 1.3s
// - second config bit 1 disables timeout
// - 200mA for 400us sets wake short
// - thermal event drops driver; rearm bit 3
// - first config bit 7 keeps driver on
// - io mode; pin edges raise interrupt
// - monitor bit 7 shows pin level
// - five sources, one line, enable bit 16
// - interrupt snapshots status, sets busy bit
// - busy clears 10us later, snapshot valid
// - first config bit 2 enables low flag
// - supply below 2.1V clears low flag
// - flag reset only by drop or disable
// - lin low, 100mA for 20us interrupts
// - open diag, driver off: bit 7 load
// - rearm write clears lin short flag
// - monitor bit 6 shows thermal occurred
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module hv_wake_pin_and_irq_status
    import hv_wake_pkg::*;
#(
    parameter int TIMEOUT_CYC = WAKE_TMO_CYC,
    parameter int WAKE_SHORT_CYC = WAKE_SC_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // axi4-lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // high voltage pins and sensors
    input wire hv_pins_in_t pins_in,
    output hv_pins_out_t pins_out,
    // processor interrupt
    output logic hv_irq_line
);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int SW = $clog2(WAKE_SHORT_CYC + 1);
    localparam int LW = $clog2(LIN_SC_CYC + 1);
    localparam int AW = $clog2(HV_LAT_CYC + 1);

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic w_have;
        logic [7:0] waddr;
        logic [7:0] wbyte;
        logic wbit16;
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic [7:0] act0;
        logic [7:0] act1;
        logic pend;
        logic pend_sel;
        logic [7:0] pend_data;
        logic [AW-1:0] lat_cnt;
        hv_pins_in_t sync1;
        hv_pins_in_t sync2;
        logic pin_prev;
        logic hot_prev;
        logic wake_on;
        logic [TW-1:0] tmo_cnt;
        logic [SW-1:0] wsc_cnt;
        logic [LW-1:0] lsc_cnt;
        logic mon_wake_sc;
        logic mon_lin_sc;
        logic low_supply_flag;
        logic hot;
        logic hot_lock;
        logic irq_en;
        logic [N_SRC-1:0] sta;
        logic [7:0] data;
        logic busy;
        logic [AW-1:0] snap_cnt;
        hv_pins_out_t pins;
        logic irq;
    } st_t;

    st_t st;
    st_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] monitor(input st_t s);
        logic [7:0] m;
        m = 8'h00;
        m[MON_WAKE_SC] = s.mon_wake_sc;
        m[MON_LIN_SC] = s.mon_lin_sc;
        m[MON_LVF] = s.low_supply_flag & s.act0[CFG0_LVF_EN];
        m[MON_HOT] = s.hot;
        // pin comparator only reported when a mode selects it
        if (s.act1[CFG1_IO_MODE] || s.act1[CFG1_OC_DIAG]) begin
            m[MON_PIN] = s.sync2.wake_pin_in;
        end
        return m;
    endfunction

    function automatic logic [31:0] read_word(input st_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == OFS_CFG_FIRST) begin
            r[7:0] = s.cfg0;
        end else if (a == OFS_CFG_SECOND) begin
            r[7:0] = s.cfg1;
        end else if (a == OFS_MONITOR) begin
            r[7:0] = monitor(s);
        end else if (a == OFS_STATUS) begin
            r[N_SRC-1:0] = s.sta;
        end else if (a == OFS_COMMAND) begin
            r[CMD_BUSY] = s.busy | s.pend;
        end else if (a == OFS_DATA) begin
            r[7:0] = s.data;
        end else if (a == OFS_IRQ_ENABLE) begin
            r[CPU_IRQ_ENABLE_HV] = s.irq_en;
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == OFS_CFG_FIRST) || (a == OFS_CFG_SECOND) || (a == OFS_MONITOR)
            || (a == OFS_STATUS) || (a == OFS_COMMAND) || (a == OFS_DATA)
            || (a == OFS_IRQ_ENABLE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [N_SRC-1:0] evt;
        logic [N_SRC-1:0] clr;
        logic pin_edge;
        evt = '0;
        clr = '0;
        pin_edge = 1'b0;
        next_st = st;

        // two-flop synchronisers; sync1 feeds sync2 only
        next_st.sync1 = pins_in;
        next_st.sync2 = st.sync1;
        next_st.pin_prev = st.sync2.wake_pin_in;
        next_st.hot_prev = st.sync2.thermal_event;

        // write channel: address and data taken in either order
        if (awvalid && st.awready) begin
            next_st.aw_have = 1'b1;
            next_st.waddr = awaddr;
        end
        if (wvalid && st.wready) begin
            next_st.w_have = 1'b1;
            next_st.wbyte = wstrb[0] ? wdata[7:0] : 8'h00;
            // kept apart so the lane choice never depends on which channel came first
            next_st.wbit16 = wstrb[2] & wdata[CPU_IRQ_ENABLE_HV];
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        // a config write waits while the previous one is still crossing
        if (st.aw_have && st.w_have && !st.bvalid && !st.pend) begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(st.waddr) ? RESP_OKAY : RESP_SLVERR;
            if (st.waddr == OFS_CFG_FIRST) begin
                next_st.cfg0 = st.wbyte;
                next_st.pend = 1'b1;
                next_st.pend_sel = 1'b0;
                next_st.pend_data = st.wbyte;
                next_st.lat_cnt = '0;
            end else if (st.waddr == OFS_CFG_SECOND) begin
                next_st.cfg1 = st.wbyte;
                next_st.pend = 1'b1;
                next_st.pend_sel = 1'b1;
                next_st.pend_data = st.wbyte;
                next_st.lat_cnt = '0;
            end else if (st.waddr == OFS_IRQ_ENABLE) begin
                next_st.irq_en = st.wbit16;
            end
        end
        next_st.awready = !next_st.aw_have;
        next_st.wready = !next_st.w_have;

        // read channel: one cycle from address to data
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word(st, araddr);
            next_st.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            // reading the snapshot acknowledges the sources it reported
            if (araddr == OFS_DATA && !st.busy) begin
                clr = st.data[N_SRC-1:0];
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // wake driver timeout
        if (st.wake_on && !st.act1[CFG1_NO_TMO]) begin
            if (st.tmo_cnt == TW'(TIMEOUT_CYC - 1)) begin
                next_st.wake_on = 1'b0;
                next_st.tmo_cnt = '0;
            end else begin
                next_st.tmo_cnt = st.tmo_cnt + 1'b1;
            end
        end else begin
            next_st.tmo_cnt = '0;
        end

        // wake short: saturating count, restarts when the overload goes away
        if (st.wake_on && st.sync2.wake_overcurrent) begin
            if (st.wsc_cnt != SW'(WAKE_SHORT_CYC)) begin
                next_st.wsc_cnt = st.wsc_cnt + 1'b1;
            end
            if (st.wsc_cnt == SW'(WAKE_SHORT_CYC - 1)) begin
                next_st.mon_wake_sc = 1'b1;
                evt[SRC_WAKE_SC] = 1'b1;
            end
        end else begin
            next_st.wsc_cnt = '0;
        end

        // lin short only qualifies while lin is driven low
        if (st.sync2.lin_drive_low && st.sync2.lin_overcurrent) begin
            if (st.lsc_cnt != LW'(LIN_SC_CYC)) begin
                next_st.lsc_cnt = st.lsc_cnt + 1'b1;
            end
            if (st.lsc_cnt == LW'(LIN_SC_CYC - 1)) begin
                next_st.mon_lin_sc = 1'b1;
                evt[SRC_LIN_SC] = 1'b1;
            end
        end else begin
            next_st.lsc_cnt = '0;
        end

        // thermal shutdown
        if (st.sync2.thermal_event && !st.hot_prev) begin
            next_st.hot = 1'b1;
            evt[SRC_HOT] = 1'b1;
            if (!st.act0[CFG0_KEEP_ON_HOT]) begin
                next_st.wake_on = 1'b0;
                next_st.hot_lock = 1'b1;
            end
        end

        // io mode edges, either direction
        pin_edge = st.sync2.wake_pin_in ^ st.pin_prev;
        if (st.act1[CFG1_IO_MODE] && pin_edge) begin
            evt[SRC_EDGE] = 1'b1;
        end

        // low supply flag drops while enabled
        if (st.act0[CFG0_LVF_EN] && st.low_supply_flag && st.sync2.supply_low) begin
            next_st.low_supply_flag = 1'b0;
            evt[SRC_LVF] = 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////
        // config reaches the hv side after the serial interface latency
        if (st.pend) begin
            if (st.lat_cnt == AW'(HV_LAT_CYC - 1)) begin
                next_st.pend = 1'b0;
                if (!st.pend_sel) begin
                    next_st.act0 = st.pend_data;
                    // a write of a one re-asserts unless hot_lock is set; every write restarts the timer
                    next_st.wake_on = st.pend_data[CFG0_DRIVE] & !next_st.hot_lock;
                    next_st.tmo_cnt = '0;
                    if (!st.pend_data[CFG0_LVF_EN]) begin
                        next_st.low_supply_flag = 1'b0;
                    end else if (!st.act0[CFG0_LVF_EN]) begin
                        next_st.low_supply_flag = 1'b1;
                    end
                end else begin
                    next_st.act1 = st.pend_data;
                    if (st.pend_data[CFG1_REARM]) begin
                        // a fault seen in the same cycle as the rearm wins over it
                        next_st.hot_lock = evt[SRC_HOT] & !st.act0[CFG0_KEEP_ON_HOT];
                        next_st.hot = st.sync2.thermal_event;
                        next_st.mon_lin_sc = evt[SRC_LIN_SC];
                        next_st.mon_wake_sc = evt[SRC_WAKE_SC];
                        next_st.wake_on = st.act0[CFG0_DRIVE] & !next_st.hot_lock;
                        next_st.tmo_cnt = '0;
                    end
                end
            end else begin
                next_st.lat_cnt = st.lat_cnt + 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // sticky sources: a new event wins over the acknowledge
        next_st.sta = (st.sta & ~clr) | evt;

        // automatic status snapshot into the data register
        if (st.busy) begin
            if (st.snap_cnt == AW'(HV_LAT_CYC - 1)) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.snap_cnt = st.snap_cnt + 1'b1;
            end
        end else if (st.irq_en && (evt != '0)) begin
            next_st.busy = 1'b1;
            next_st.snap_cnt = '0;
            next_st.data = 8'(next_st.sta);
        end

        next_st.irq = st.irq_en && (next_st.sta != '0);

        // pin drive: high-side only, pull-down removed for open-load test
        next_st.pins.wake_pin_out = 1'b1;
        next_st.pins.wake_pin_oe_n = !next_st.wake_on;
        next_st.pins.pulldown_en = !next_st.act1[CFG1_OC_DIAG];
        next_st.pins.oc_res_en = next_st.act1[CFG1_OC_DIAG] & !next_st.wake_on;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.cfg0 <= CFG_FIRST_RST;
            st.cfg1 <= CFG_SECOND_RST;
            st.act0 <= CFG_FIRST_RST;
            st.act1 <= CFG_SECOND_RST;
            st.pins.wake_pin_out <= 1'b1;
            st.pins.wake_pin_oe_n <= 1'b1;
            st.pins.pulldown_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rresp = st.rresp;
    assign rdata = st.rdata;
    assign pins_out = st.pins;
    assign hv_irq_line = st.irq;
endmodule
`default_nettype wire

// [sim/hv_far_side.sv]
// far-side model: wake pin wire, external load and hv sensors
`timescale 1ns/1ps
`default_nettype none
module hv_far_side
    import hv_wake_pkg::*;
(
    // from the block
    input wire hv_pins_out_t pins_out,
    // scenario controls
    input wire logic ext_high,
    input wire logic load_on,
    input wire logic short_gnd,
    input wire logic [3:0] sense,
    // to the block
    output wire hv_pins_in_t pins_in
);
    logic drv;
    logic lvl;
    assign drv = !pins_out.wake_pin_oe_n;
    // released pin: pull-down wins unless ext_high drives it or the diag resistor lifts an open pin
    assign lvl = drv ? pins_out.wake_pin_out : ext_high | (pins_out.oc_res_en & !load_on);
    // wake overcurrent only exists while the high side drives into the short
    assign pins_in = {lvl, drv & short_gnd, sense};
endmodule
`default_nettype wire

// [sim/hv_wake_sva.sv]
// port-level assertions for the wake pin and hv interrupt block
`timescale 1ns/1ps
`default_nettype none
module hv_wake_sva
    import hv_wake_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // pins and interrupt
    input wire hv_pins_out_t pins_out,
    input wire logic hv_irq_line
);
    int since_wr;
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    // the driver can only come on once a write has crossed the slow hv link
    always_ff @(posedge core_clk) begin
        if (sys_rst || $rose(bvalid)) begin
            since_wr <= 0;
        end else if (since_wr < 1000) begin
            since_wr <= since_wr + 1;
        end
    end
    reset_state_a: assert property (
        $fell(sys_rst) |-> pins_out.wake_pin_oe_n && pins_out.pulldown_en
            && !pins_out.oc_res_en && !hv_irq_line)
        else $error("driver or irq active after reset");
    drive_high_a: assert property (pins_out.wake_pin_out)
        else $error("wake driver not high side");
    diag_off_a: assert property (pins_out.oc_res_en |-> pins_out.wake_pin_oe_n)
        else $error("diag resistor on while driving");
    drive_delay_a: assert property (
        $fell(pins_out.wake_pin_oe_n) |-> since_wr >= 198)
        else $error("driver came on too early");
    wr_take_a: assert property (
        awvalid && awready && wvalid && wready |=> !awready && !wready)
        else $error("write ready not dropped");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response not held");
    read_turn_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read answer late");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    cover property ($fell(pins_out.wake_pin_oe_n));
    cover property ($rose(hv_irq_line));
    cover property ($rose(pins_out.oc_res_en));
endmodule
bind hv_wake_pin_and_irq_status hv_wake_sva hv_wake_sva_inst (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rvalid(rvalid), .rready(rready),
    .pins_out(pins_out), .hv_irq_line(hv_irq_line)
);
`default_nettype wire

// [sim/hv_wake_pin_and_irq_status_bench.sv]
// self-checking bench for the wake pin and hv interrupt block
`timescale 1ns/1ps
`default_nettype none
module hv_wake_pin_and_irq_status_bench import hv_wake_pkg::*;;
    localparam int TMO = 60;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, hv_irq_line;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata;
    hv_pins_in_t pins_in;
    hv_pins_out_t pins_out;
    logic ext_high = 1'b0, load_on = 1'b0, short_gnd = 1'b0;
    logic [3:0] sense = 4'h0;
    int bad_count = 0;
    int cmp_count = 0;
    always #25 core_clk = ~core_clk;
    hv_wake_pin_and_irq_status #(.TIMEOUT_CYC(TMO), .WAKE_SHORT_CYC(20))
        hv_wake_pin_and_irq_status_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pins_in(pins_in), .pins_out(pins_out),
        .hv_irq_line(hv_irq_line));
    hv_far_side hv_far_side_inst (.pins_out(pins_out), .ext_high(ext_high),
        .load_on(load_on), .short_gnd(short_gnd), .sense(sense), .pins_in(pins_in));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rbit(input logic [7:0] a, input int b, input logic e);
        logic [31:0] d;
        rd(a, d);
        chk(32'(d[b]), 32'(e));
    endtask
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        chk(32'(pins_out.wake_pin_oe_n), 1);
        chk(32'(pins_out.pulldown_en), 1);
        rd(OFS_CFG_FIRST, d);
        chk(d, 32'(CFG_FIRST_RST));
        rd(8'h1c, d);
        chk(32'(rsp), 32'(RESP_SLVERR));
        wr(8'h1c, 32'h0000_0010);
        chk(32'(rsp), 32'(RESP_SLVERR));
        $display("reset test done");
    endtask
    task automatic t_drive();
        wr(OFS_CFG_FIRST, 1 << CFG0_DRIVE);
        wt(150);
        chk(32'(pins_out.wake_pin_oe_n), 1);
        wt(70);
        chk(32'(pins_out.wake_pin_oe_n), 0);
        wt(TMO + 10);
        chk(32'(pins_out.wake_pin_oe_n), 1);
        // timer off: software must end the drive itself
        wr(OFS_CFG_SECOND, 1 << CFG1_NO_TMO);
        wr(OFS_CFG_FIRST, 1 << CFG0_DRIVE);
        wt(300);
        chk(32'(pins_out.wake_pin_oe_n), 0);
        wr(OFS_CFG_FIRST, 0);
        wt(210);
        chk(32'(pins_out.wake_pin_oe_n), 1);
        $display("drive test done");
    endtask
    task automatic t_short();
        logic [31:0] d;
        wr(OFS_IRQ_ENABLE, 1 << CPU_IRQ_ENABLE_HV);
        wr(OFS_CFG_FIRST, 1 << CFG0_DRIVE);
        wt(210);
        short_gnd <= 1'b1;
        wt(30);
        short_gnd <= 1'b0;
        rbit(OFS_MONITOR, MON_WAKE_SC, 1);
        chk(32'(hv_irq_line), 1);
        rbit(OFS_COMMAND, CMD_BUSY, 1);
        do rd(OFS_COMMAND, d); while (d[CMD_BUSY] !== 1'b0);
        rd(OFS_DATA, d);
        chk(d, 1 << SRC_WAKE_SC);
        chk(32'(hv_irq_line), 0);
        $display("short test done");
    endtask
    task automatic t_hot();
        logic [31:0] d;
        wr(OFS_IRQ_ENABLE, 0);
        sense <= 4'h2;
        wt(6);
        sense <= 4'h0;
        chk(32'(pins_out.wake_pin_oe_n), 1);
        chk(32'(hv_irq_line), 0);
        rbit(OFS_MONITOR, MON_HOT, 1);
        wr(OFS_IRQ_ENABLE, 1 << CPU_IRQ_ENABLE_HV);
        wt(3);
        chk(32'(hv_irq_line), 1);
        wr(OFS_CFG_SECOND, (1 << CFG1_NO_TMO) | (1 << CFG1_REARM));
        wt(210);
        chk(32'(pins_out.wake_pin_oe_n), 0);
        rd(OFS_MONITOR, d);
        chk(d, 0);
        wr(OFS_IRQ_ENABLE, 0);
        wr(OFS_CFG_FIRST, (1 << CFG0_DRIVE) | (1 << CFG0_KEEP_ON_HOT));
        wt(210);
        sense <= 4'h2;
        wt(6);
        sense <= 4'h0;
        chk(32'(pins_out.wake_pin_oe_n), 0);
        $display("thermal test done");
    endtask
    task automatic t_flags();
        wr(OFS_CFG_FIRST, 1 << CFG0_LVF_EN);
        wt(210);
        rbit(OFS_MONITOR, MON_LVF, 1);
        sense <= 4'h1;
        wt(5);
        sense <= 4'h0;
        wt(5);
        rbit(OFS_MONITOR, MON_LVF, 0);
        sense <= 4'hc;
        wt(LIN_SC_CYC + 10);
        sense <= 4'h0;
        rbit(OFS_MONITOR, MON_LIN_SC, 1);
        rbit(OFS_STATUS, SRC_LIN_SC, 1);
        wr(OFS_CFG_SECOND, (1 << CFG1_NO_TMO) | (1 << CFG1_REARM));
        wt(210);
        rbit(OFS_MONITOR, MON_LIN_SC, 0);
        $display("flag test done");
    endtask
    task automatic t_pin();
        wr(OFS_CFG_SECOND, 1 << CFG1_IO_MODE);
        wt(210);
        ext_high <= 1'b1;
        wt(5);
        rbit(OFS_MONITOR, MON_PIN, 1);
        rbit(OFS_STATUS, SRC_EDGE, 1);
        ext_high <= 1'b0;
        wr(OFS_CFG_SECOND, 1 << CFG1_OC_DIAG);
        wt(210);
        chk(32'(pins_out.oc_res_en), 1);
        chk(32'(pins_out.pulldown_en), 0);
        rbit(OFS_MONITOR, MON_PIN, 1);
        load_on <= 1'b1;
        wt(5);
        rbit(OFS_MONITOR, MON_PIN, 0);
        $display("pin test done");
    endtask
    ////////////////////////////////////////
    initial begin
        wt(10);
        sys_rst <= 1'b0;
        wt(1);
        t_reset();
        t_drive();
        t_short();
        t_hot();
        t_flags();
        t_pin();
        report_and_stop();
    end
    // every test finishes in well under this span
    initial begin
        wt(30000);
        bad_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
